// ===== rtl/rmsl_latch.sv
// Reset mode strap latch: captures mode and flash visibility at reset release.
`timescale 1ns/10ps
`include "rmsl_params.svh"
module rmsl_latch
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [31:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic modeSelectHi,
   input wire logic modeSelectMid,
   input wire logic modeSelectLo,
   input wire logic flashStrapPin,
   input wire logic debugActivateCmd,
   output logic [2:0] opMode,
   output logic flashMapped,
   output logic debugActive,
   output logic singleChip,
   output logic expandedBus,
   output logic wideBus,
   output logic emulationMode,
   output logic specialMode
);

   rmsl_sync_if syncIf ();

   rmsl_pkg::rmsl_mode_t mode_q;
   rmsl_pkg::rmsl_mode_t strapMode;
   rmsl_pkg::rmsl_mode_t wrMode;
   logic flashVisible_q;
   logic debugActive_q;
   logic badStrap_q;
   logic modeLocked_q;
   logic flashLocked_q;
   logic rstSeen_q;
   logic captureNow;
   logic strapFlash;
   logic [31:0] prdata_q;
   logic setupRead;
   logic accessWr;
   logic mapped;
   logic [31:0] readMux;
   logic modeWrOk;
   logic flashWrOk;
   logic modeWrite;
   logic flashWrite;

   // Strap pins come from outside the clock domain and pass the synchroniser.
   assign syncIf.raw = {modeSelectHi, modeSelectMid, modeSelectLo, flashStrapPin};

   rmsl_strap_sync u_sync
   (
      .sys_clk(sys_clk),
      .syncIf(syncIf)
   );

   assign strapMode = rmsl_pkg::rmsl_mode_t'(syncIf.stable[3:1]);
   assign strapFlash = syncIf.stable[0];

   // Flash visibility as each mode decodes the flash strap.
   function automatic logic flashDecode(input rmsl_pkg::rmsl_mode_t m, input logic strap);
      logic vis;
      vis = 1'b1;
      unique case (m)
         rmsl_pkg::RMSL_SPECIAL_SINGLE: vis = 1'b1;
         rmsl_pkg::RMSL_EMU_NARROW: vis = ~strap;
         rmsl_pkg::RMSL_SPECIAL_TEST: vis = 1'b0;
         rmsl_pkg::RMSL_EMU_WIDE: vis = ~strap;
         rmsl_pkg::RMSL_NORMAL_SINGLE: vis = 1'b1;
         rmsl_pkg::RMSL_NORMAL_NARROW: vis = strap;
         rmsl_pkg::RMSL_SPECIAL_PERIPH: vis = 1'b1;
         rmsl_pkg::RMSL_NORMAL_WIDE: vis = strap;
      endcase
      return vis;
   endfunction

   // The release of reset is the first edge seen with reset low after it was high.
   always_ff @(posedge sys_clk)
   begin
      rstSeen_q <= rst;
   end

   assign captureNow = rstSeen_q & ~rst;

   // APB decode; the slave never inserts wait states.
   assign mapped = (paddr == `RMSL_MODE_OFFSET) || (paddr == `RMSL_MISC_OFFSET) ||
                   (paddr == `RMSL_STAT_OFFSET);
   assign setupRead = psel & ~penable & ~pwrite;
   assign accessWr = psel & penable & pwrite & pstrb[0] & ~rst;
   assign pready = psel & penable;
   assign pslverr = psel & penable & ~mapped;
   assign wrMode = rmsl_pkg::rmsl_mode_t'(pwdata[`RMSL_MODE_MSB:`RMSL_MODE_LSB]);

   // Special modes other than peripheral may move freely; normal and peripheral modes get one move, and only to a normal mode.
   // Peripheral mode is never reachable by software, since it fights the external bus.
   assign modeWrOk = (wrMode != rmsl_pkg::RMSL_SPECIAL_PERIPH) &&
                     (~mode_q[2] || (~modeLocked_q && wrMode[2]));
   assign flashWrOk = ~mode_q[2] || ~flashLocked_q;
   assign modeWrite = accessWr && (paddr == `RMSL_MODE_OFFSET) && modeWrOk;
   assign flashWrite = accessWr && (paddr == `RMSL_MISC_OFFSET) && flashWrOk;

   // Mode bits: reset value, strap capture at release, then only guarded writes.
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         mode_q <= rmsl_pkg::rmsl_mode_t'(`RMSL_MODE_RST);
      end
      else if (captureNow)
      begin
         mode_q <= strapMode;
      end
      else if (modeWrite)
      begin
         mode_q <= wrMode;
      end
   end

   // Write-once locks for normal modes; a later reset reopens them.
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         modeLocked_q <= 1'b0;
         flashLocked_q <= 1'b0;
      end
      else
      begin
         if (modeWrite && mode_q[2])
         begin
            modeLocked_q <= 1'b1;
         end
         if (flashWrite && mode_q[2])
         begin
            flashLocked_q <= 1'b1;
         end
      end
   end

   // Flash visibility: decoded strap at release, later changed only by software.
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         flashVisible_q <= `RMSL_FLASH_RST;
      end
      else if (captureNow)
      begin
         flashVisible_q <= flashDecode(strapMode, strapFlash);
      end
      else if (flashWrite)
      begin
         flashVisible_q <= pwdata[`RMSL_FLASH_BIT];
      end
   end

   // Background debug: active at once only in special single chip, else on command.
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         debugActive_q <= `RMSL_DEBUG_RST;
      end
      else if (captureNow)
      begin
         // A command that lands in the release cycle is kept rather than lost to the capture.
         debugActive_q <= (strapMode == rmsl_pkg::RMSL_SPECIAL_SINGLE) ||
                          debugActivateCmd;
      end
      else if (debugActivateCmd)
      begin
         debugActive_q <= 1'b1;
      end
   end

   // Flag a forbidden peripheral-mode strap so software can see the board fault.
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         badStrap_q <= 1'b0;
      end
      else if (captureNow)
      begin
         badStrap_q <= (strapMode == rmsl_pkg::RMSL_SPECIAL_PERIPH);
      end
   end

   // Read data is taken in the setup cycle so prdata comes from a flip-flop.
   always_comb
   begin
      readMux = 32'h0000_0000;
      if (paddr == `RMSL_MODE_OFFSET)
      begin
         readMux[`RMSL_MODE_MSB:`RMSL_MODE_LSB] = mode_q;
      end
      else if (paddr == `RMSL_MISC_OFFSET)
      begin
         readMux[`RMSL_FLASH_BIT] = flashVisible_q;
      end
      else if (paddr == `RMSL_STAT_OFFSET)
      begin
         readMux[`RMSL_STAT_DEBUG_BIT] = debugActive_q;
         readMux[`RMSL_STAT_BADSTRAP_BIT] = badStrap_q;
         readMux[`RMSL_STAT_LOCK_BIT] = modeLocked_q;
         readMux[`RMSL_STAT_PINS_MSB:`RMSL_STAT_PINS_LSB] = syncIf.stable;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         prdata_q <= `RMSL_RDATA_RST;
      end
      else if (setupRead)
      begin
         prdata_q <= readMux;
      end
   end

   assign prdata = prdata_q;

   // Mode decode drives memory map and bus arrangement for the rest of the chip.
   assign opMode = mode_q;
   assign flashMapped = flashVisible_q;
   assign debugActive = debugActive_q;
   assign singleChip = (mode_q == rmsl_pkg::RMSL_SPECIAL_SINGLE) ||
                       (mode_q == rmsl_pkg::RMSL_NORMAL_SINGLE);
   assign expandedBus = ~singleChip && (mode_q != rmsl_pkg::RMSL_SPECIAL_PERIPH);
   assign wideBus = mode_q[1] & (mode_q[0] | ~mode_q[2]);
   assign emulationMode = ~mode_q[2] & mode_q[0];
   assign specialMode = ~mode_q[2] || (mode_q == rmsl_pkg::RMSL_SPECIAL_PERIPH);

   // Checks on capture, decode and write protection.
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   // The release is taken from the registered reset, so this stays plain combinational logic.
   logic releaseEdge;
   assign releaseEdge = rstSeen_q && !rst;

   capture_mode_a: assert property (releaseEdge |=> opMode == $past(syncIf.stable[3:1]))
      else $error("Mode bits differ from straps at reset release.");
   capture_flash_a: assert property (releaseEdge |=>
      flashMapped == flashDecode(rmsl_pkg::rmsl_mode_t'($past(syncIf.stable[3:1])),
                                 $past(syncIf.stable[0])))
      else $error("Flash visibility wrong after reset release.");
   special_single_a: assert property (releaseEdge && syncIf.stable[3:1] == 3'b000 |=>
      flashMapped && debugActive)
      else $error("Special single chip did not map flash and start debug.");
   debug_idle_a: assert property (releaseEdge && syncIf.stable[3:1] != 3'b000
      && !debugActivateCmd ##1 !debugActivateCmd [*2] |-> !debugActive)
      else $error("Debug active without a command.");
   emu_narrow_a: assert property (releaseEdge && syncIf.stable == 4'b0011 |=> !flashMapped)
      else $error("Emulation narrow with high strap mapped flash.");
   test_mode_a: assert property (releaseEdge && syncIf.stable[3:1] == 3'b010 |=>
      !flashMapped && wideBus && expandedBus)
      else $error("Special test mode decode wrong.");
   mode_hold_a: assert property (!captureNow && !modeWrite |=> $stable(opMode))
      else $error("Mode changed without capture or write.");
   periph_write_a: assert property (accessWr && paddr == `RMSL_MODE_OFFSET &&
      pwdata[2:0] == 3'b110 |=> $stable(opMode))
      else $error("Software reached peripheral mode.");
   zero_wait_a: assert property (psel && !penable |=> !penable || pready)
      else $error("Access phase not answered at once.");
   debug_set_a: assert property (debugActivateCmd |=> debugActive)
      else $error("Debug command did not activate background debug.");
   mode_lock_a: assert property (modeLocked_q && accessWr &&
      paddr == `RMSL_MODE_OFFSET |=> $stable(opMode))
      else $error("Locked normal mode accepted another mode write.");

   mode_write_c: cover property (modeWrite ##1 opMode == $past(pwdata[2:0]));
   debug_cmd_c: cover property (!debugActive ##1 debugActive && !captureNow);
   flash_write_c: cover property (flashWrite ##1 $changed(flashMapped));
   unmapped_c: cover property (pslverr);
   mode_refuse_c: cover property (accessWr && paddr == `RMSL_MODE_OFFSET && !modeWrOk);

endmodule // rmsl_latch

// ===== rtl/rmsl_params.svh
// Constants for the reset mode strap latch: offsets, field positions, reset values.
`ifndef RMSL_PARAMS_SVH
`define RMSL_PARAMS_SVH

// Register byte offsets on the APB bus.
`define RMSL_MODE_OFFSET 32'h0000_0000
`define RMSL_MISC_OFFSET 32'h0000_0004
`define RMSL_STAT_OFFSET 32'h0000_0008

// Field positions.
`define RMSL_MODE_LSB 0
`define RMSL_MODE_MSB 2
`define RMSL_FLASH_BIT 0
`define RMSL_STAT_DEBUG_BIT 0
`define RMSL_STAT_BADSTRAP_BIT 1
`define RMSL_STAT_LOCK_BIT 2
`define RMSL_STAT_PINS_LSB 4
`define RMSL_STAT_PINS_MSB 7

// Values held while reset is asserted.
`define RMSL_MODE_RST 3'h0
`define RMSL_FLASH_RST 1'h0
`define RMSL_DEBUG_RST 1'h0
`define RMSL_RDATA_RST 32'h0000_0000

// Strap pins: three mode selects and the flash strap.
`define RMSL_STRAP_W 4

`endif

// ===== rtl/rmsl_pkg.sv
// Types shared by the reset mode strap latch.
package rmsl_pkg;

   // Operating modes, coded as the three mode-select levels hi, mid, lo.
   typedef enum logic [2:0] {
      RMSL_SPECIAL_SINGLE = 3'b000,
      RMSL_EMU_NARROW = 3'b001,
      RMSL_SPECIAL_TEST = 3'b010,
      RMSL_EMU_WIDE = 3'b011,
      RMSL_NORMAL_SINGLE = 3'b100,
      RMSL_NORMAL_NARROW = 3'b101,
      RMSL_SPECIAL_PERIPH = 3'b110,
      RMSL_NORMAL_WIDE = 3'b111
   } rmsl_mode_t;

endpackage

// ===== rtl/rmsl_sync_if.sv
// Interface between the strap synchroniser and the latch logic.
`timescale 1ns/10ps
interface rmsl_sync_if;
   logic [3:0] raw;
   logic [3:0] stable;
   modport sync (input raw, output stable);
   modport user (output raw, input stable);
endinterface // rmsl_sync_if

// ===== rtl/rmsl_strap_sync.sv
// Three-stage synchroniser with agreement filter for the strap pins.
`timescale 1ns/10ps
module rmsl_strap_sync
(
   input wire logic sys_clk,
   rmsl_sync_if.sync syncIf
);

   logic [3:0] stage1_q;
   logic [3:0] stage2_q;
   logic [3:0] stage3_q;
   logic [3:0] stable_q;

   // Pins are not reset so that they keep tracking the straps while reset is held.
   always_ff @(posedge sys_clk)
   begin
      stage1_q <= syncIf.raw;
      stage2_q <= stage1_q;
      stage3_q <= stage2_q;
   end

   // A new level counts only once the second and third stages agree.
   always_ff @(posedge sys_clk)
   begin
      if (stage2_q == stage3_q)
      begin
         stable_q <= stage3_q;
      end
   end

   assign syncIf.stable = stable_q;

endmodule // rmsl_strap_sync

// ===== bench/rmsl_strap_model.sv
// Board strapping model that drives the mode and flash strap pins.
`timescale 1ns/10ps
module rmsl_strap_model
(
   input wire logic sys_clk,
   input wire logic [3:0] want,
   output logic modeSelectHi,
   output logic modeSelectMid,
   output logic modeSelectLo,
   output logic flashStrapPin
);
   logic [3:0] pinsQ = 4'h0;
   // Pins follow the request one edge later and hold steady while it holds.
   // The forbidden peripheral code is turned into normal wide, since a board must not strap it.
   always @(posedge sys_clk)
   begin
      pinsQ <= (want[3:1] == 3'h6) ? {3'h7, want[0]} : want;
   end
   assign {modeSelectHi, modeSelectMid, modeSelectLo, flashStrapPin} = pinsQ;
endmodule // rmsl_strap_model

// ===== bench/reset_mode_strap_latch_tb.sv
// Self-checking bench for the reset mode strap latch.
`timescale 1ns/10ps
`include "rmsl_params.svh"
module reset_mode_strap_latch_tb;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [31:0] paddr = 32'h0000_0000;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [3:0] want = 4'h0;
   logic hi, mid, lo, fl;
   logic dbgCmd = 1'b0;
   logic [2:0] opMode;
   logic flashMapped, debugActive, singleChip, wideBus;
   logic expandedBus, emulationMode, specialMode;
   logic exFl;
   logic [31:0] rd;
   logic er;
   int errTotal = 0;
   int cmpCount = 0;
   int cyc = 0;

   always #4 sys_clk = ~sys_clk;

   rmsl_strap_model strap_u (.sys_clk(sys_clk), .want(want), .modeSelectHi(hi),
      .modeSelectMid(mid), .modeSelectLo(lo), .flashStrapPin(fl));

   rmsl_latch dut_u (.sys_clk(sys_clk), .rst(rst), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .modeSelectHi(hi), .modeSelectMid(mid),
      .modeSelectLo(lo), .flashStrapPin(fl), .debugActivateCmd(dbgCmd), .opMode(opMode),
      .flashMapped(flashMapped), .debugActive(debugActive), .singleChip(singleChip),
      .expandedBus(expandedBus), .wideBus(wideBus), .emulationMode(emulationMode),
      .specialMode(specialMode));

   // Ends the run with the verdict.
   task automatic conclude();
      if (errTotal == 0 && cmpCount > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // Counts a comparison and reports a mismatch at once.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmpCount++;
      if (got !== exp)
      begin
         errTotal++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // APB transfer; request held until pready is seen high at a rising edge.
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask

   // Expected flash visibility for a mode code and strap level.
   function automatic logic expFlash(input logic [2:0] m, input logic s);
      case (m)
         3'h0, 3'h4: return 1'b1;
         3'h1, 3'h3: return ~s;
         3'h2: return 1'b0;
         default: return s;
      endcase
   endfunction

   // A hang is cut short after far more cycles than the tests need.
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         errTotal++;
         conclude();
      end
   end

   // Every legal strap combination is booted, checked, and then disturbed.
   initial
   begin
      for (int m = 0; m < 8; m++)
      begin
         for (int s = 0; s < 2; s++)
         begin
            if (m == 6)
               continue;
            @(posedge sys_clk);
            want <= {m[2:0], s[0]};
            rst <= 1'b1;
            repeat (20) @(posedge sys_clk);
            rst <= 1'b0;
            repeat (3) @(posedge sys_clk);
            exFl = expFlash(m[2:0], s[0]);
            chk({29'h0, opMode}, m);
            chk({31'h0, flashMapped}, {31'h0, exFl});
            chk({31'h0, debugActive}, {31'h0, m == 0});
            chk({31'h0, singleChip}, {31'h0, m == 0 || m == 4});
            chk({31'h0, wideBus}, {31'h0, m == 2 || m == 3 || m == 7});
            chk({31'h0, expandedBus}, {31'h0, m != 0 && m != 4});
            chk({31'h0, emulationMode}, {31'h0, m == 1 || m == 3});
            chk({31'h0, specialMode}, {31'h0, m < 4});
            apb(1'b0, `RMSL_MODE_OFFSET, 32'h0000_0000);
            chk({29'h0, rd[2:0]}, m);
            apb(1'b0, `RMSL_MISC_OFFSET, 32'h0000_0000);
            chk({31'h0, rd[0]}, {31'h0, exFl});
            want <= ~{m[2:0], s[0]};
            repeat (8) @(posedge sys_clk);
            chk({28'h0, opMode, flashMapped}, {28'h0, m[2:0], exFl});
            apb(1'b0, `RMSL_STAT_OFFSET, 32'h0000_0000);
            chk({24'h0, rd[7:0]}, {24'h0, hi, mid, lo, fl, 3'h0, m == 0});
         end
      end
      dbgCmd <= 1'b1;
      @(posedge sys_clk);
      dbgCmd <= 1'b0;
      @(posedge sys_clk);
      chk({31'h0, debugActive}, 32'h0000_0001);
      apb(1'b1, `RMSL_MODE_OFFSET, 32'h0000_0000);
      chk({29'h0, opMode}, 32'h0000_0007);
      apb(1'b1, `RMSL_MODE_OFFSET, 32'h0000_0006);
      chk({29'h0, opMode}, 32'h0000_0007);
      apb(1'b1, `RMSL_MODE_OFFSET, 32'h0000_0005);
      chk({29'h0, opMode}, 32'h0000_0005);
      apb(1'b1, `RMSL_MODE_OFFSET, 32'h0000_0007);
      chk({29'h0, opMode}, 32'h0000_0005);
      apb(1'b1, `RMSL_MISC_OFFSET, 32'h0000_0000);
      chk({31'h0, flashMapped}, 32'h0000_0000);
      apb(1'b1, `RMSL_MISC_OFFSET, 32'h0000_0001);
      chk({31'h0, flashMapped}, 32'h0000_0000);
      apb(1'b0, `RMSL_STAT_OFFSET, 32'h0000_0000);
      chk({29'h0, rd[2:0]}, 32'h0000_0005);
      apb(1'b0, 32'h0000_0010, 32'h0000_0000);
      chk({rd[30:0], er}, 32'h0000_0001);
      conclude();
   end
endmodule // reset_mode_strap_latch_tb
